// *** array_model.sv ***
// Behavioural capacitor array and comparator steered by the block.
`timescale 1ns/10ps
`default_nettype none
module array_model
    import sar_ctrl_pkg::*;
(
    input  wire logic [RESULT_WIDTH-1:0] arrayToRef,
    input  wire logic [RESULT_WIDTH-1:0] heldValue,
    output logic                         comparatorHigh
);
    // The held charge is ideal, so the input must stay put for the whole conversion.
    assign comparatorHigh = (heldValue >= arrayToRef);
endmodule
`default_nettype wire

// *** sar_adc_host_control.sv ***
// Control and sequencing logic of a sampling successive-approximation converter.
`timescale 1ns/10ps
`default_nettype none

module sar_adc_host_control
    import sar_ctrl_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    chipEnable,
    input  wire logic                    deviceSelectN,
    input  wire logic                    readConvertN,
    input  wire logic                    byteAddrShortCycle,
    input  wire logic                    wordWidthSelect,
    input  wire logic                    legacyEmulationMode,
    input  wire logic                    comparatorHigh,
    output logic                         busy,
    output logic [RESULT_WIDTH-1:0]      resultBusOut,
    output logic [RESULT_WIDTH-1:0]      resultBusOeN,
    output logic                         msbSampleSwitch,
    output logic                         comparatorZeroSwitch,
    output logic [RESULT_WIDTH-1:0]      arrayToRef
);

    ctrl_type                ctrlMeta_r;
    ctrl_type                ctrl_r;
    ctrl_type                ctrlPrev_r;
    logic                    emuMeta_r;
    logic                    emu_r;
    logic                    cmpMeta_r;
    logic                    cmp_r;

    conv_state_type          state_r;
    logic [CNT_WIDTH-1:0]    cnt_r;
    logic [3:0]              bitIdx_r;
    logic                    shortCycle_r;
    logic                    resultShort_r;
    logic [RESULT_WIDTH-1:0] trial_r;
    logic [RESULT_WIDTH-1:0] result_r;
    logic [RESULT_WIDTH-1:0] result_nxt;
    logic                    busy_r;
    logic                    startEvent;
    logic                    qualified;
    logic                    qualifiedPrev;
    logic                    lastBit;
    logic                    readEnable;

    // Every control pin is asynchronous to clk, so each passes two flip-flops first.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrlMeta_r <= '0;
            ctrl_r     <= '0;
            ctrlPrev_r <= '0;
            emuMeta_r  <= 1'b0;
            emu_r      <= 1'b0;
            cmpMeta_r  <= 1'b0;
            cmp_r      <= 1'b0;
        end else begin
            ctrlMeta_r <= '{chipEnable, deviceSelectN, readConvertN,
                            byteAddrShortCycle, wordWidthSelect};
            ctrl_r     <= ctrlMeta_r;
            ctrlPrev_r <= ctrl_r;
            emuMeta_r  <= legacyEmulationMode;
            emu_r      <= emuMeta_r;
            cmpMeta_r  <= comparatorHigh;
            cmp_r      <= cmpMeta_r;
        end
    end

    // A start is the moment the three-way qualifier becomes true, whichever pin
    // completed it; several pins changing together still give one start.
    function automatic logic startQualified(input ctrl_type c);
        startQualified = c.chipEnable && !c.deviceSelectN && !c.readConvertN;
    endfunction

    assign qualified     = startQualified(ctrl_r);
    assign qualifiedPrev = startQualified(ctrlPrev_r);
    assign startEvent    = qualified && !qualifiedPrev;

    assign lastBit = (bitIdx_r == (shortCycle_r ? LAST_BIT_8 : LAST_BIT_12));

    // Sequencer: tracking, optional acquisition, one trial per bit period, latch.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r  <= ST_TRACK;
            cnt_r    <= CNT_ZERO;
            bitIdx_r <= FIRST_BIT;
        end else begin
            case (state_r)
                ST_TRACK: begin
                    cnt_r    <= CNT_ZERO;
                    bitIdx_r <= FIRST_BIT;
                    if (startEvent) begin
                        state_r <= emu_r ? ST_ACQUIRE : ST_TRIAL;
                    end
                end
                ST_ACQUIRE: begin
                    if (cnt_r == ACQ_CNT_MAX) begin
                        cnt_r   <= CNT_ZERO;
                        state_r <= ST_TRIAL;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_TRIAL: begin
                    if (cnt_r == BIT_CNT_MAX) begin
                        cnt_r <= CNT_ZERO;
                        if (lastBit) begin
                            state_r <= ST_LATCH;
                        end else begin
                            bitIdx_r <= bitIdx_r - 1'b1;
                        end
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_LATCH: begin
                    if (cnt_r == LATCH_CNT_MAX) begin
                        cnt_r   <= CNT_ZERO;
                        state_r <= ST_TRACK;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                default: begin
                    state_r  <= ST_TRACK;
                    cnt_r    <= CNT_ZERO;
                    bitIdx_r <= FIRST_BIT;
                end
            endcase
        end
    end

    // The length is latched at every start transition, even one that arrives
    // mid-conversion; only the length is affected, the sequence is not restarted.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shortCycle_r <= 1'b0;
        end else if (startEvent) begin
            shortCycle_r <= ctrl_r.byteAddrShortCycle;
        end
    end

    // Trial register: set the bit under test, keep or drop it by the comparator.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trial_r <= RESULT_RESET;
        end else if (state_r == ST_TRACK && startEvent) begin
            trial_r <= RESULT_RESET;
        end else if (state_r == ST_TRIAL) begin
            if (cnt_r == CNT_ZERO) begin
                trial_r[bitIdx_r] <= 1'b1;
            end else if (cnt_r == BIT_CNT_MAX) begin
                trial_r[bitIdx_r] <= cmp_r;
            end
        end
    end

    // The last decision is still in flight in the trial register, so the
    // result takes the comparator directly for the bit under test.
    always_comb begin
        result_nxt           = trial_r;
        result_nxt[bitIdx_r] = cmp_r;
        if (shortCycle_r) begin
            result_nxt[NIBBLE_WIDTH-1:0] = NIBBLE_ZERO;
        end
    end

    // The result is latched on entry to the latch state, before busy falls.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_r      <= RESULT_RESET;
            resultShort_r <= 1'b0;
        end else if (state_r == ST_TRIAL && cnt_r == BIT_CNT_MAX && lastBit) begin
            result_r      <= result_nxt;
            resultShort_r <= shortCycle_r;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_r <= 1'b0;
        end else if (state_r == ST_TRACK) begin
            busy_r <= startEvent;
        end else if (state_r == ST_LATCH && cnt_r == LATCH_CNT_MAX) begin
            busy_r <= 1'b0;
        end
    end

    assign busy = busy_r;

    // Array switches: sampling outside a conversion; once the last bit is
    // resolved the sampler tracks again while busy still stands.
    always_comb begin
        if (state_r == ST_ACQUIRE || state_r == ST_TRIAL) begin
            msbSampleSwitch      = 1'b0;
            comparatorZeroSwitch = 1'b0;
            arrayToRef           = trial_r;
        end else begin
            msbSampleSwitch      = 1'b1;
            comparatorZeroSwitch = 1'b1;
            arrayToRef           = RESULT_RESET;
        end
    end

    assign readEnable = ctrl_r.chipEnable && !ctrl_r.deviceSelectN
                        && ctrl_r.readConvertN && !busy_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resultBusOut <= RESULT_RESET;
        end else if (ctrl_r.wordWidthSelect) begin
            resultBusOut <= result_r;
        end else if (ctrl_r.byteAddrShortCycle) begin
            resultBusOut <= {NIBBLE_ZERO, result_r[NIBBLE_WIDTH-1:0], NIBBLE_ZERO};
        end else begin
            resultBusOut <= {NIBBLE_ZERO, result_r[RESULT_WIDTH-1:NIBBLE_WIDTH]};
        end
    end

    // Output enables are active low; byte mode drives only the low eight lines,
    // so the two bytes can never drive together however the select moves.
    always_comb begin
        resultBusOeN = {RESULT_WIDTH{1'b1}};
        if (readEnable) begin
            if (ctrl_r.wordWidthSelect) begin
                resultBusOeN = '0;
            end else begin
                resultBusOeN[BYTE_WIDTH-1:0] = '0;
            end
        end
    end

endmodule

`default_nettype wire

// *** sar_adc_host_control_properties.sv ***
// Temporal checks on the ports of the converter control block.
`timescale 1ns/10ps
`default_nettype none
module sar_adc_host_control_properties
    import sar_ctrl_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    resetn,
    input wire logic                    chipEnable,
    input wire logic                    deviceSelectN,
    input wire logic                    readConvertN,
    input wire logic                    byteAddrShortCycle,
    input wire logic                    wordWidthSelect,
    input wire logic                    legacyEmulationMode,
    input wire logic                    comparatorHigh,
    input wire logic                    busy,
    input wire logic [RESULT_WIDTH-1:0] resultBusOut,
    input wire logic [RESULT_WIDTH-1:0] resultBusOeN,
    input wire logic                    msbSampleSwitch,
    input wire logic                    comparatorZeroSwitch,
    input wire logic [RESULT_WIDTH-1:0] arrayToRef
);
    localparam logic [11:0] SHORT_LEN = 12'(SHORT_BITS * BIT_CYCLES + LATCH_CYCLES);
    localparam logic [11:0] LONG_LEN  = 12'(RESULT_WIDTH * BIT_CYCLES + LATCH_CYCLES);
    logic [11:0] busyCnt_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Counts sampled busy cycles so the full conversion length can be judged on the fall.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busyCnt_r <= 12'h000;
        end else begin
            busyCnt_r <= busy ? busyCnt_r + 12'h001 : 12'h000;
        end
    end

    chk_busy_floats: assert property (busy |-> &resultBusOeN)
        else $error("data driven during conversion");
    chk_idle_samples: assert property (!busy |-> msbSampleSwitch && comparatorZeroSwitch
        && arrayToRef == 12'h000)
        else $error("array not sampling while idle");
    chk_start_holds: assert property ($rose(busy) && !legacyEmulationMode |-> !msbSampleSwitch
        && !comparatorZeroSwitch ##1 arrayToRef == 12'h800)
        else $error("hold or first trial wrong at start");
    chk_chip_off: assert property ((!chipEnable || deviceSelectN)[*4] |-> &resultBusOeN)
        else $error("data driven while chip off");
    chk_convert_floats: assert property ((!readConvertN)[*4] |-> &resultBusOeN)
        else $error("data driven while convert is low");
    chk_byte_lines: assert property ((!wordWidthSelect)[*4] |-> &resultBusOeN[11:8])
        else $error("upper lines driven in byte mode");
    chk_busy_length: assert property ($fell(busy) |-> legacyEmulationMode
        || busyCnt_r == SHORT_LEN || busyCnt_r == LONG_LEN)
        else $error("conversion length wrong");
    chk_track_before: assert property ($fell(busy) |-> $past(msbSampleSwitch))
        else $error("sampler not tracking before busy fell");
    chk_start_delay: assert property (!busy && chipEnable && !deviceSelectN
        && $fell(readConvertN) ##1 !readConvertN |-> ##[1:3] busy)
        else $error("conversion did not start");
endmodule

bind sar_adc_host_control sar_adc_host_control_properties sar_adc_host_control_properties_inst (
    .clk, .resetn, .chipEnable, .deviceSelectN, .readConvertN, .byteAddrShortCycle,
    .wordWidthSelect, .legacyEmulationMode, .comparatorHigh, .busy, .resultBusOut,
    .resultBusOeN, .msbSampleSwitch, .comparatorZeroSwitch, .arrayToRef);
`default_nettype wire

// *** sar_ctrl_pkg.sv ***
// Shared constants and types for the converter control block.
package sar_ctrl_pkg;

    localparam int          RESULT_WIDTH   = 12;
    localparam int          SHORT_BITS     = 8;
    localparam int          BYTE_WIDTH     = 8;
    localparam int          NIBBLE_WIDTH   = 4;
    localparam int          CLK_PERIOD_PS  = 8000;

    // Conversion times excluding acquisition, in nanoseconds.
    localparam int          CONV12_TIME_NS = 18000;
    localparam int          CONV8_TIME_NS  = 12000;
    // Acquisition delay in the legacy emulation mode, in nanoseconds.
    localparam int          ACQ_TIME_NS    = 4000;
    // Settle time after the result is latched before busy falls, in nanoseconds.
    localparam int          LATCH_TIME_NS  = 16;

    // One bit is resolved per bit period; longest time rounds down.
    localparam int          BIT_CYCLES     = (CONV12_TIME_NS * 1000) / (CLK_PERIOD_PS * RESULT_WIDTH);
    localparam int          ACQ_CYCLES     = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          LATCH_CYCLES   = (LATCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int          CNT_WIDTH      = 10;
    localparam logic [CNT_WIDTH-1:0] BIT_CNT_MAX   = CNT_WIDTH'(BIT_CYCLES - 1);
    localparam logic [CNT_WIDTH-1:0] ACQ_CNT_MAX   = CNT_WIDTH'(ACQ_CYCLES - 1);
    localparam logic [CNT_WIDTH-1:0] LATCH_CNT_MAX = CNT_WIDTH'(LATCH_CYCLES - 1);
    localparam logic [CNT_WIDTH-1:0] CNT_ZERO      = 10'h000;

    localparam logic [3:0]  LAST_BIT_12    = 4'h0;
    localparam logic [3:0]  LAST_BIT_8     = 4'h4;
    localparam logic [3:0]  FIRST_BIT      = 4'hb;
    localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 12'h000;
    localparam logic [NIBBLE_WIDTH-1:0] NIBBLE_ZERO  = 4'h0;

    // Control inputs as seen after synchronisation.
    typedef struct packed {
        logic chipEnable;
        logic deviceSelectN;
        logic readConvertN;
        logic byteAddrShortCycle;
        logic wordWidthSelect;
    } ctrl_type;

    // Capacitor array switch settings: one bit per element, 1 = reference.
    typedef struct packed {
        logic                    msbSampleSwitch;
        logic                    comparatorZeroSwitch;
        logic [RESULT_WIDTH-1:0] arrayToRef;
    } array_type;

    typedef enum logic [2:0] {
        ST_TRACK,
        ST_ACQUIRE,
        ST_TRIAL,
        ST_LATCH
    } conv_state_type;

endpackage

// *** testbench.sv ***
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sar_ctrl_pkg::*;
    logic        clk, resetn, chipEnable, deviceSelectN, readConvertN, byteAddrShortCycle;
    logic        wordWidthSelect, comparatorHigh, busy, msbSampleSwitch, comparatorZeroSwitch;
    logic        legacyEmulationMode;
    logic [11:0] resultBusOut, resultBusOeN, arrayToRef, heldValue;
    int          n_errors, checked;
    int          cycles = 0;

    sar_adc_host_control sar_adc_host_control_inst (.clk, .resetn, .chipEnable, .deviceSelectN,
        .readConvertN, .byteAddrShortCycle, .wordWidthSelect, .legacyEmulationMode,
        .comparatorHigh, .busy, .resultBusOut, .resultBusOeN, .msbSampleSwitch,
        .comparatorZeroSwitch, .arrayToRef);
    array_model array_model_inst (.arrayToRef, .heldValue, .comparatorHigh);

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Five conversions of at most about 2800 cycles each fit well inside this ceiling.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    // Pins in order: chip enable, select, read/convert, byte address, word width.
    task automatic drive(input logic [4:0] pins);
        step(1);
        {chipEnable, deviceSelectN, readConvertN, byteAddrShortCycle, wordWidthSelect} = pins;
    endtask

    task automatic convert(input string name, input logic [11:0] value, input logic [2:0] pre,
                           input logic aStart, input logic glitch, input logic aGlitch);
        int          n;
        logic        shortRun;
        logic [11:0] len;
        heldValue = value;
        drive({pre, aStart, 1'h1});
        step(4);
        if (!pre[2] || pre[1]) begin
            check("idle busy", {11'h0, busy}, 12'h000);
            check("idle enables", resultBusOeN, 12'hfff);
        end
        drive({3'b100, aStart, 1'h1});
        step(5);
        check("busy at start", {11'h0, busy}, 12'h001);
        check("sampler held", {10'h0, msbSampleSwitch, comparatorZeroSwitch}, 12'h000);
        drive({3'b101, aStart, 1'h1});
        step(4);
        check("enables in conversion", resultBusOeN, 12'hfff);
        if (glitch) begin
            drive({3'b100, aGlitch, 1'h1});
            step(4);
            drive({3'b101, aGlitch, 1'h1});
        end
        shortRun = glitch ? aGlitch : aStart;
        len = 12'((shortRun ? 8 : 12) * BIT_CYCLES + LATCH_CYCLES + 1
                  + (legacyEmulationMode ? ACQ_CYCLES : 0));
        n = 0;
        while (busy === 1'h1 && n < 3000) begin
            step(1);
            n++;
        end
        check("busy length", {11'h0, n > int'(len) - 16 && n < int'(len)}, 12'h001);
        drive({3'b101, 1'h1, 1'h1});
        step(3);
        check("word data", resultBusOut, shortRun ? value & 12'hff0 : value);
        check("word enables", resultBusOeN, 12'h000);
        $display("test %s done", name);
    endtask

    initial begin
        {chipEnable, deviceSelectN, readConvertN, byteAddrShortCycle, wordWidthSelect} = 5'h15;
        resetn = 1'h0;
        heldValue = 12'h000;
        legacyEmulationMode = 1'h0;
        n_errors = 0;
        checked = 0;
        step(10);
        check("reset enables", resultBusOeN, 12'hfff);
        check("reset array", arrayToRef, 12'h000);
        check("reset switches", {10'h0, msbSampleSwitch, comparatorZeroSwitch}, 12'h003);
        resetn = 1'h1;
        convert("convert fall", 12'ha5c, 3'b101, 1'h0, 1'h0, 1'h0);
        convert("enable rise short", 12'h3c7, 3'b000, 1'h1, 1'h0, 1'h0);
        convert("select fall relatch", 12'h5a3, 3'b110, 1'h0, 1'h1, 1'h1);
        convert("all at once", 12'h801, 3'b011, 1'h0, 1'h0, 1'h0);
        drive(5'b10100);
        step(3);
        check("high byte", {4'h0, resultBusOut[7:0]}, 12'h080);
        check("byte enables", resultBusOeN, 12'hf00);
        drive(5'b10110);
        step(3);
        check("low byte", {4'h0, resultBusOut[7:0]}, 12'h010);
        check("low byte enables", resultBusOeN, 12'hf00);
        $display("test byte reads done");
        legacyEmulationMode = 1'h1;
        convert("emulation", 12'h6b2, 3'b101, 1'h0, 1'h0, 1'h0);
        test_done();
    end
endmodule
`default_nettype wire
